// file: pkg/pmsv_defines.vh
// Offsets, field positions, reset values and timing counts of the sequencer and voltage registers
// What this block does
// - The delay register at 0x1B holds a 3-bit start-up delay code for regulator four in bits 5:3 and for regulator three in bits 2:0, with bits 7:6 reading zero.
// - Each 3-bit delay code picks one of eight delay slots, 000 the first and 111 the eighth, in binary order.
// - The normal 8-bit voltage code of the first step-down converter is a full read/write byte at 0x20.
// - The alternate 8-bit voltage code of the first step-down converter is a full read/write byte at 0x21.
// - The normal 8-bit voltage code of the second step-down converter is a full read/write byte at 0x22.
// - The alternate 8-bit voltage code of the second step-down converter is a full read/write byte at 0x23.
// - A voltage code maps linearly to a target, 0.6000 V for code 0x00 plus 12.5 mV per step.
// - Codes from 0xD8 upward all give a 3.3000 V target, which is never exceeded.
// - All four voltage registers share the same code-to-voltage table.
// - Each converter's select bit chooses the normal register when 0 and the alternate when 1.
`ifndef PMSV_DEFINES_VH
`define PMSV_DEFINES_VH

`define PMSV_ADDR_LDO_DELAY   8'h1B
`define PMSV_ADDR_BUCK1_NORM  8'h20
`define PMSV_ADDR_BUCK1_ALT   8'h21
`define PMSV_ADDR_BUCK2_NORM  8'h22
`define PMSV_ADDR_BUCK2_ALT   8'h23

`define PMSV_DELAY_MASK       8'h3F
`define PMSV_R3_LSB           0
`define PMSV_R4_LSB           3
`define PMSV_RESET_VALUE      8'h00

// Target in units of 0.1 mV
`define PMSV_VOUT_BASE        16'h1770
`define PMSV_VOUT_STEP        16'h007D
`define PMSV_VOUT_MAX         16'h80E8
`define PMSV_SAT_CODE         8'hD8

// One delay slot, in microseconds, and its length in 25 ns cycles
`define PMSV_SLOT_US          128
`define PMSV_CLK_MHZ          40
`define PMSV_SLOT_CYCLES      (`PMSV_SLOT_US * `PMSV_CLK_MHZ)
`define PMSV_SLOT_COUNT       4'h8

`endif

// file: hdl/pmsv_seq_voltage_regs.v
// Sequencer delay and step-down voltage registers with power-up slot sequencing
`timescale 1ns/10ps
`include "pmsv_defines.vh"

module pmsv_seq_voltage_regs #(
	parameter SLOT_CYCLES = `PMSV_SLOT_CYCLES
) (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	output wire        reg_hit,
	input  wire        buck1_target_select,
	input  wire        buck2_target_select,
	input  wire        power_up_start,
	output reg  [7:0]  buck1_code,
	output reg  [7:0]  buck2_code,
	output reg  [15:0] buck1_vout,
	output reg  [15:0] buck2_vout,
	output reg         reg_three_en,
	output reg         reg_four_en,
	output wire        power_up_busy
);

	////////////////////////////////////////////////////////////////////////
	// Register file

	reg [5:0] delay_r;
	reg [5:0] delay_nxt;
	reg [7:0] buck1_norm_r;
	reg [7:0] buck1_norm_nxt;
	reg [7:0] buck1_alt_r;
	reg [7:0] buck1_alt_nxt;
	reg [7:0] buck2_norm_r;
	reg [7:0] buck2_norm_nxt;
	reg [7:0] buck2_alt_r;
	reg [7:0] buck2_alt_nxt;

	wire hit_delay = (reg_addr == `PMSV_ADDR_LDO_DELAY);
	wire hit_b1n   = (reg_addr == `PMSV_ADDR_BUCK1_NORM);
	wire hit_b1a   = (reg_addr == `PMSV_ADDR_BUCK1_ALT);
	wire hit_b2n   = (reg_addr == `PMSV_ADDR_BUCK2_NORM);
	wire hit_b2a   = (reg_addr == `PMSV_ADDR_BUCK2_ALT);

	assign reg_hit = hit_delay | hit_b1n | hit_b1a | hit_b2n | hit_b2a;

	wire [2:0] reg_three_delay_code = delay_r[`PMSV_R3_LSB +: 3];
	wire [2:0] reg_four_delay_code  = delay_r[`PMSV_R4_LSB +: 3];

	// A write lands only on a decoded address, so traffic to neighbouring
	// offsets cannot disturb a converter setting
	always @* begin
		delay_nxt      = delay_r;
		buck1_norm_nxt = buck1_norm_r;
		buck1_alt_nxt  = buck1_alt_r;
		buck2_norm_nxt = buck2_norm_r;
		buck2_alt_nxt  = buck2_alt_r;
		if (reg_wr) begin
			if (hit_delay) begin
				delay_nxt = reg_wdata[5:0];
			end
			if (hit_b1n) begin
				buck1_norm_nxt = reg_wdata;
			end
			if (hit_b1a) begin
				buck1_alt_nxt = reg_wdata;
			end
			if (hit_b2n) begin
				buck2_norm_nxt = reg_wdata;
			end
			if (hit_b2a) begin
				buck2_alt_nxt = reg_wdata;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			delay_r <= 6'h00;
		end else begin
			delay_r <= delay_nxt;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			buck1_norm_r <= `PMSV_RESET_VALUE;
		end else begin
			buck1_norm_r <= buck1_norm_nxt;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			buck1_alt_r <= `PMSV_RESET_VALUE;
		end else begin
			buck1_alt_r <= buck1_alt_nxt;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			buck2_norm_r <= `PMSV_RESET_VALUE;
		end else begin
			buck2_norm_r <= buck2_norm_nxt;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			buck2_alt_r <= `PMSV_RESET_VALUE;
		end else begin
			buck2_alt_r <= buck2_alt_nxt;
		end
	end

	// Read data is combinational from the stored value; unmapped reads give zero
	always @* begin
		case (reg_addr)
		`PMSV_ADDR_LDO_DELAY: begin
			reg_rdata = {2'h0, delay_r};
		end
		`PMSV_ADDR_BUCK1_NORM: begin
			reg_rdata = buck1_norm_r;
		end
		`PMSV_ADDR_BUCK1_ALT: begin
			reg_rdata = buck1_alt_r;
		end
		`PMSV_ADDR_BUCK2_NORM: begin
			reg_rdata = buck2_norm_r;
		end
		`PMSV_ADDR_BUCK2_ALT: begin
			reg_rdata = buck2_alt_r;
		end
		default: begin
			reg_rdata = 8'h00;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Active target per converter, one shared code table

	function [15:0] code_to_vout;
		input [7:0] code;
		begin
			if (code >= `PMSV_SAT_CODE) begin
				code_to_vout = `PMSV_VOUT_MAX;
			end else begin
				code_to_vout = `PMSV_VOUT_BASE + code * `PMSV_VOUT_STEP;
			end
		end
	endfunction

	wire [7:0] b1_sel = buck1_target_select ? buck1_alt_r : buck1_norm_r;
	wire [7:0] b2_sel = buck2_target_select ? buck2_alt_r : buck2_norm_r;

	reg [7:0]  buck1_code_nxt;
	reg [7:0]  buck2_code_nxt;
	reg [15:0] buck1_vout_nxt;
	reg [15:0] buck2_vout_nxt;

	// Targets are registered so a select flip never glitches the converter loop
	always @* begin
		buck1_code_nxt = b1_sel;
		buck2_code_nxt = b2_sel;
		buck1_vout_nxt = code_to_vout(b1_sel);
		buck2_vout_nxt = code_to_vout(b2_sel);
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			buck1_code <= 8'h00;
			buck2_code <= 8'h00;
			buck1_vout <= `PMSV_VOUT_BASE;
			buck2_vout <= `PMSV_VOUT_BASE;
		end else begin
			buck1_code <= buck1_code_nxt;
			buck2_code <= buck2_code_nxt;
			buck1_vout <= buck1_vout_nxt;
			buck2_vout <= buck2_vout_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up slot sequencer

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg        state_r;
	reg        state_nxt;
	reg [31:0] cyc_r;
	reg [31:0] cyc_nxt;
	reg [3:0]  slots_done_r;
	reg [3:0]  slots_done_nxt;

	wire slot_end = (cyc_r == SLOT_CYCLES - 1);

	always @* begin
		case (state_r)
		ST_IDLE: begin
			if (power_up_start) begin
				state_nxt = ST_RUN;
			end else begin
				state_nxt = ST_IDLE;
			end
		end
		ST_RUN: begin
			if (slot_end && slots_done_r == `PMSV_SLOT_COUNT - 4'h1) begin
				state_nxt = ST_IDLE;
			end else begin
				state_nxt = ST_RUN;
			end
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	assign power_up_busy = (state_r == ST_RUN);

	// Counters run only while busy; a start re-arms the slot count from zero
	always @* begin
		cyc_nxt        = cyc_r;
		slots_done_nxt = slots_done_r;
		if (state_r == ST_IDLE) begin
			cyc_nxt = 32'h0;
			if (power_up_start) begin
				slots_done_nxt = 4'h0;
			end
		end else if (slot_end) begin
			cyc_nxt        = 32'h0;
			slots_done_nxt = slots_done_r + 4'h1;
		end else begin
			cyc_nxt = cyc_r + 32'h1;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			cyc_r <= 32'h0;
		end else begin
			cyc_r <= cyc_nxt;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			slots_done_r <= 4'h0;
		end else begin
			slots_done_r <= slots_done_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Regulator enables

	// Enables stay on once raised; a new power-up start drops them first
	wire [5:0] codes = {reg_four_delay_code, reg_three_delay_code};
	wire [1:0] slot_passed;
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_ldo
			assign slot_passed[g] = (slots_done_r > {1'b0, codes[3*g +: 3]});
		end
	endgenerate

	reg reg_three_en_nxt;
	reg reg_four_en_nxt;

	always @* begin
		reg_three_en_nxt = reg_three_en | slot_passed[0];
		reg_four_en_nxt  = reg_four_en | slot_passed[1];
		if (state_r == ST_IDLE && power_up_start) begin
			reg_three_en_nxt = 1'b0;
			reg_four_en_nxt  = 1'b0;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			reg_three_en <= 1'b0;
		end else begin
			reg_three_en <= reg_three_en_nxt;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			reg_four_en <= 1'b0;
		end else begin
			reg_four_en <= reg_four_en_nxt;
		end
	end

endmodule // pmsv_seq_voltage_regs

// file: verification/pmsv_regs_checker.sv
// Port assertions for the sequencer and voltage registers
`timescale 1ns/10ps
module pmsv_regs_checker #(
	parameter SLOT_CYCLES = 4
) (
	input wire        clk_sys,
	input wire        rst,
	input wire        reg_wr,
	input wire        reg_hit,
	input wire        power_up_start,
	input wire        reg_three_en,
	input wire        reg_four_en,
	input wire        power_up_busy,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata,
	input wire [7:0]  buck1_code,
	input wire [7:0]  buck2_code,
	input wire [15:0] buck1_vout,
	input wire [15:0] buck2_vout
);
	reg [15:0] busy_cnt_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_start; power_up_start && !power_up_busy; endsequence
	sequence s_wr(a); reg_wr && reg_addr == a ##1 reg_addr == a; endsequence
	always @(posedge clk_sys)
		busy_cnt_r <= (rst || (power_up_start && !power_up_busy)) ? 16'h0000 :
			busy_cnt_r + {15'h0000, power_up_busy};
	a_hit_decode: assert property (reg_hit == (reg_addr == 8'h1B || reg_addr[7:2] == 6'h08))
		else $error("bad hit");
	a_unmapped_zero: assert property (!reg_hit |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_delay_readback: assert property (s_wr(8'h1B) |-> reg_rdata == ($past(reg_wdata) & 8'h3F))
		else $error("delay readback wrong");
	a_buck_readback: assert property (s_wr(8'h20) |-> reg_rdata == $past(reg_wdata))
		else $error("voltage readback wrong");
	a_buck1_table: assert property (buck1_vout == (buck1_code >= 8'hD8 ? 16'h80E8 :
		16'h1770 + 16'h007D * buck1_code)) else $error("buck1 target wrong");
	a_buck2_table: assert property (buck2_vout == (buck2_code >= 8'hD8 ? 16'h80E8 :
		16'h1770 + 16'h007D * buck2_code)) else $error("buck2 target wrong");
	a_start_quiet: assert property (s_start |=> (power_up_busy && !reg_three_en && !reg_four_en)[*5])
		else $error("enable before first slot");
	a_enable_sticky: assert property (reg_three_en && !(power_up_start && !power_up_busy)
		|=> reg_three_en) else $error("enable dropped");
	// Guarded against a busy flag cut short by reset
	a_busy_length: assert property ($fell(power_up_busy) && !$past(rst) |-> busy_cnt_r == 8 * SLOT_CYCLES)
		else $error("sequence length wrong");
endmodule // pmsv_regs_checker
bind pmsv_seq_voltage_regs pmsv_regs_checker #(.SLOT_CYCLES(SLOT_CYCLES)) chk (.clk_sys, .rst,
	.reg_wr, .reg_hit, .power_up_start, .reg_three_en, .reg_four_en, .power_up_busy, .reg_addr,
	.reg_wdata, .reg_rdata, .buck1_code, .buck2_code, .buck1_vout, .buck2_vout);

// file: verification/pmsv_host_model.sv
// Host model driving the register byte port
`timescale 1ns/10ps
module pmsv_host_model (
	input wire       clk_sys,
	input wire [7:0] reg_rdata,
	output reg       reg_wr,
	output reg [7:0] reg_addr,
	output reg [7:0] reg_wdata
);
	initial {reg_wr, reg_addr, reg_wdata} = 17'h00000;
	task wr(input [7:0] a, d);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			// Inverted idle data exposes a write that samples late
			reg_wdata <= ~d;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			@(posedge clk_sys);
			d = reg_rdata;
		end
	endtask
endmodule // pmsv_host_model

// file: verification/test_pmsv_seq_voltage_regs.sv
// Self-checking bench for the sequencer and voltage registers
`timescale 1ns/10ps
module test_pmsv_seq_voltage_regs;
	reg         clk_sys = 1'b0, rst = 1'b1, sel = 1'b0, start = 1'b0;
	wire        reg_wr, reg_three_en, reg_four_en;
	wire [7:0]  reg_rdata, reg_addr, reg_wdata;
	wire [15:0] buck1_vout, buck2_vout;
	reg  [7:0]  d;
	integer     err_total = 0, num_checks = 0, cyc = 0, i, n, t3, t4;
	always #12.5 clk_sys = ~clk_sys;
	pmsv_host_model host (.clk_sys, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
	pmsv_seq_voltage_regs #(.SLOT_CYCLES(4)) uut (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rdata, .reg_hit(), .buck1_target_select(sel), .buck2_target_select(sel),
		.power_up_start(start), .buck1_code(), .buck2_code(), .buck1_vout, .buck2_vout,
		.reg_three_en, .reg_four_en, .power_up_busy());
	task chk(input [15:0] got, exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rchk(input [7:0] a, exp);
		begin
			host.rd(a, d);
			chk({8'h00, d}, {8'h00, exp});
		end
	endtask
	task vchk(input s, input [15:0] e1, e2);
		begin
			@(posedge clk_sys);
			sel <= s;
			repeat (2) @(posedge clk_sys);
			#1;
			chk(buck1_vout, e1);
			chk(buck2_vout, e2);
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", num_checks, err_total);
			if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total = err_total + 1;
			results;
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 0; i < 5; i = i + 1) rchk(i ? 8'h1F + i[7:0] : 8'h1B, 8'h00);
		host.wr(8'h1B, 8'hFF);
		rchk(8'h1B, 8'h3F);
		host.wr(8'h24, 8'h5A);
		rchk(8'h24, 8'h00);
		host.wr(8'h20, 8'hD7);
		host.wr(8'h21, 8'hD8);
		host.wr(8'h22, 8'h01);
		host.wr(8'h23, 8'hFF);
		rchk(8'h20, 8'hD7);
		rchk(8'h21, 8'hD8);
		rchk(8'h22, 8'h01);
		rchk(8'h23, 8'hFF);
		vchk(1'b0, 16'h806B, 16'h17ED);
		vchk(1'b1, 16'h80E8, 16'h80E8);
		for (i = 0; i < 8; i = i + 1) begin
			host.wr(8'h1B, {2'b00, 3'h7 - i[2:0], i[2:0]});
			start <= 1'b1;
			t3 = 0;
			t4 = 0;
			for (n = 1; n < 40; n = n + 1) begin
				@(posedge clk_sys);
				// A second start mid-sequence must not restart the slots
				start <= (n == 9);
				#1;
				if (reg_three_en && t3 == 0) t3 = n;
				if (reg_four_en && t4 == 0) t4 = n;
			end
			chk(t3[15:0], 4 * i + 6);
			chk(t4[15:0], 34 - 4 * i);
		end
		results;
	end
endmodule // test_pmsv_seq_voltage_regs
